// File: rtl/gps_map.svh
`ifndef GPS_MAP_SVH
`define GPS_MAP_SVH
// Timing figures in their own units
`define GPS_CLK_HZ 10000000
`define GPS_CLK_NS 100
`define GPS_TOGGLE_MS 200
`define GPS_SHUTDOWN_MS 1000
`define GPS_HIB_DELAY_MS 10
`define GPS_UTC_DELAY_MS 300
`define GPS_PPS_MIN_NS 620
`define GPS_PPS_MAX_NS 710
`define GPS_PPS_WIDTH_MS 100
`define GPS_PTF_PERIOD_S 7200
`define GPS_FIX_MS 50
// Derived cycle counts; least times round up, longest round down
`define GPS_CYC_PER_MS (`GPS_CLK_HZ / 1000)
`define GPS_TOGGLE_CYC (`GPS_TOGGLE_MS * `GPS_CYC_PER_MS)
`define GPS_TOGGLE_MIN_CYC (`GPS_TOGGLE_CYC / 2)
`define GPS_SHUTDOWN_CYC (`GPS_SHUTDOWN_MS * `GPS_CYC_PER_MS)
`define GPS_HIB_DELAY_CYC (`GPS_HIB_DELAY_MS * `GPS_CYC_PER_MS)
`define GPS_UTC_DELAY_CYC (`GPS_UTC_DELAY_MS * `GPS_CYC_PER_MS)
`define GPS_PPS_DELAY_CYC ((`GPS_PPS_MIN_NS + `GPS_CLK_NS - 1) / `GPS_CLK_NS)
`define GPS_PPS_WIDTH_CYC (`GPS_PPS_WIDTH_MS * `GPS_CYC_PER_MS)
`define GPS_SECOND_CYC `GPS_CLK_HZ
`define GPS_PTF_PERIOD_SEC `GPS_PTF_PERIOD_S
`define GPS_FIX_CYC (`GPS_FIX_MS * `GPS_CYC_PER_MS)
// Rate selector field values
`define GPS_SEL_5HZ 4'h6
`define GPS_SEL_1HZ 4'h7
`endif

// File: rtl/gps_pkg.sv
package gps_pkg;
  typedef enum logic [6:0] {
    GPS_OFF = 7'h01,
    GPS_FULL = 7'h02,
    GPS_SHUT = 7'h04,
    GPS_HIB_WAIT = 7'h08,
    GPS_HIB = 7'h10,
    GPS_AWARE = 7'h20,
    GPS_PTF = 7'h40
  } gps_state_t;

  // Host commands decoded from the message streams
  typedef struct packed {
    logic shutdown;
    logic enter_aware;
    logic enter_ptf;
    logic rate_valid;
    logic [3:0] rate_sel;
  } gps_cmd_t;

  typedef struct packed {
    logic second_pulse_output;
    logic utc_msg_strobe;
    logic nav_strobe;
    logic fast_rate;
  } gps_time_t;
endpackage

// File: rtl/gps_pulse_timer.sv
`timescale 1ns/1ns
// Measures a high pulse on a synchronised input; pulses once on its fall if its length lies within MIN_CYC+1..MAX_CYC+1 cycles
module gps_pulse_timer #(
  parameter int MIN_CYC = 1000000,
  parameter int MAX_CYC = 4000000
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Pin and result
  input wire logic pin_async,
  output logic pulse_ok
);
  logic s1_q, s2_q, s3_q;
  logic level_q, level_d;
  logic [31:0] cnt_q, cnt_d;
  logic ok_d;

  always_comb
  begin
    level_d = level_q;
    cnt_d = cnt_q;
    ok_d = 1'b0;
    // Change counts once second and third stage agree
    if (s2_q == s3_q)
    begin
      level_d = s3_q;
    end
    if (level_q)
    begin
      if (cnt_q != 32'hffffffff)
      begin
        cnt_d = cnt_q + 32'h1;
      end
    end
    else
    begin
      cnt_d = 32'h0;
    end
    if (level_q && !level_d)
    begin
      ok_d = (cnt_q >= 32'(MIN_CYC)) && (cnt_q <= 32'(MAX_CYC));
    end
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
      level_q <= 1'b0;
      cnt_q <= 32'h0;
      pulse_ok <= 1'b0;
    end
    else
    begin
      s1_q <= pin_async;
      s2_q <= s1_q;
      s3_q <= s2_q;
      level_q <= level_d;
      cnt_q <= cnt_d;
      pulse_ok <= ok_d;
    end
  end
endmodule

// File: rtl/gps_power_seq.sv
`timescale 1ns/1ns
`include "gps_map.svh"
// Function
// - Full power shuts down on a 200 ms toggle or shutdown message.
// - Shutdown completes within one second; host keeps supply meanwhile.
// - Aware mode exits and requests a fix on a 200 ms toggle.
// - Push-to-fix sleeps up to two hours, waking periodically to refresh.
// - Push-to-fix computes an extra fix on a 200 ms toggle.
// - Hibernate follows a short delay after the shutdown phase started by command or toggle.
// - A 200 ms toggle wakes the module from hibernate.
// - Second pulse comes 620 to 710 ns after each system second in full power with time locked.
// - UTC messages follow the second pulse by about 300 ms.
// - Navigation rate defaults to 1 Hz; 5 Hz selectable by command.
// - Rate selector value 6 enables 5 Hz, value 7 returns to 1 Hz.
module gps_power_seq
  import gps_pkg::*;
#(
  parameter int TOGGLE_MIN_CYC = `GPS_TOGGLE_MIN_CYC,
  parameter int TOGGLE_MAX_CYC = 2 * `GPS_TOGGLE_CYC,
  parameter int SHUTDOWN_CYC = `GPS_SHUTDOWN_CYC,
  parameter int HIB_DELAY_CYC = `GPS_HIB_DELAY_CYC,
  parameter int SECOND_CYC = `GPS_SECOND_CYC,
  parameter int UTC_DELAY_CYC = `GPS_UTC_DELAY_CYC,
  parameter int PPS_WIDTH_CYC = `GPS_PPS_WIDTH_CYC,
  parameter int PTF_PERIOD_SEC = `GPS_PTF_PERIOD_SEC,
  parameter int FIX_CYC = `GPS_FIX_CYC
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Power toggle pin from host
  input wire logic power_toggle,
  // Decoded host messages, one-cycle strobes
  input wire gps_pkg::gps_cmd_t cmd,
  input wire logic cmd_valid,
  // Satellite time valid
  input wire logic time_locked,
  // Power and status
  output logic wake_indicator_output,
  output logic core_power_on,
  output logic rtc_sram_retain,
  output logic shutdown_done,
  output logic fix_request,
  // Timing
  output gps_pkg::gps_time_t timing
);
  import gps_pkg::*;

  logic toggle_ok;
  gps_state_t st_q, st_d;
  logic [31:0] tmr_q, tmr_d;
  logic [31:0] sec_q, sec_d;
  logic [31:0] ptf_q, ptf_d;
  logic [31:0] pps_q, pps_d;
  logic [31:0] fix_q, fix_d;
  logic [2:0] sub_q, sub_d;
  logic fast_q, fast_d;
  logic done_q, done_d;
  logic fixreq_q, fixreq_d;
  logic utc_q, utc_d;
  logic nav_q, nav_d;
  logic ppso_q, ppso_d;
  logic pps_arm_q, pps_arm_d;
  logic utc_arm_q, utc_arm_d;
  logic [31:0] utc_cnt_q, utc_cnt_d;
  logic sec_tick;

  gps_pulse_timer #(
    .MIN_CYC(TOGGLE_MIN_CYC),
    .MAX_CYC(TOGGLE_MAX_CYC)
  ) u_toggle (
    .clk(clk),
    .reset_n(reset_n),
    .pin_async(power_toggle),
    .pulse_ok(toggle_ok)
  );

  assign sec_tick = (sec_q == 32'(SECOND_CYC - 1));

  // Power state machine
  always_comb
  begin
    st_d = st_q;
    tmr_d = tmr_q;
    ptf_d = ptf_q;
    fix_d = fix_q;
    done_d = done_q;
    fixreq_d = 1'b0;
    case (st_q)
      GPS_OFF:
      begin
        // Waiting for the host start pulse
        if (toggle_ok)
        begin
          st_d = GPS_FULL;
          done_d = 1'b0;
        end
      end
      GPS_FULL:
      begin
        if (toggle_ok || (cmd_valid && cmd.shutdown))
        begin
          st_d = GPS_SHUT;
          tmr_d = 32'h0;
        end
        else if (cmd_valid && cmd.enter_aware)
        begin
          st_d = GPS_AWARE;
        end
        else if (cmd_valid && cmd.enter_ptf)
        begin
          st_d = GPS_PTF;
          ptf_d = 32'h0;
          fix_d = 32'h0;
        end
      end
      GPS_SHUT:
      begin
        // Orderly shutdown, bounded by one second
        tmr_d = tmr_q + 32'h1;
        if (tmr_q >= 32'(SHUTDOWN_CYC - HIB_DELAY_CYC - 1))
        begin
          st_d = GPS_HIB_WAIT;
          tmr_d = 32'h0;
        end
      end
      GPS_HIB_WAIT:
      begin
        // Short settle before hibernate
        tmr_d = tmr_q + 32'h1;
        if (tmr_q >= 32'(HIB_DELAY_CYC - 1))
        begin
          st_d = GPS_HIB;
          done_d = 1'b1;
        end
      end
      GPS_HIB:
      begin
        if (toggle_ok)
        begin
          st_d = GPS_FULL;
          done_d = 1'b0;
        end
      end
      GPS_AWARE:
      begin
        if (toggle_ok)
        begin
          st_d = GPS_FULL;
          fixreq_d = 1'b1;
        end
      end
      GPS_PTF:
      begin
        // Sleep with periodic refresh wakeups
        if (fix_q != 32'h0)
        begin
          fix_d = fix_q - 32'h1;
        end
        if (sec_tick)
        begin
          ptf_d = ptf_q + 32'h1;
        end
        if (toggle_ok)
        begin
          fixreq_d = 1'b1;
          fix_d = 32'(FIX_CYC);
        end
        else if (sec_tick && (ptf_q >= 32'(PTF_PERIOD_SEC - 1)))
        begin
          fixreq_d = 1'b1;
          ptf_d = 32'h0;
          fix_d = 32'(FIX_CYC);
        end
        if (cmd_valid && cmd.shutdown)
        begin
          st_d = GPS_SHUT;
          tmr_d = 32'h0;
        end
      end
      default:
      begin
        st_d = GPS_OFF;
      end
    endcase
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      st_q <= GPS_OFF;
      tmr_q <= 32'h0;
      ptf_q <= 32'h0;
      fix_q <= 32'h0;
      done_q <= 1'b0;
      fixreq_q <= 1'b0;
    end
    else
    begin
      st_q <= st_d;
      tmr_q <= tmr_d;
      ptf_q <= ptf_d;
      fix_q <= fix_d;
      done_q <= done_d;
      fixreq_q <= fixreq_d;
    end
  end

  // Second timebase, second pulse, UTC and navigation strobes
  always_comb
  begin
    sec_d = sec_tick ? 32'h0 : sec_q + 32'h1;
    sub_d = sub_q;
    fast_d = fast_q;
    pps_d = pps_q;
    pps_arm_d = pps_arm_q;
    ppso_d = ppso_q;
    utc_arm_d = utc_arm_q;
    utc_cnt_d = utc_cnt_q;
    utc_d = 1'b0;
    nav_d = 1'b0;
    if (cmd_valid && cmd.rate_valid)
    begin
      if (cmd.rate_sel == `GPS_SEL_5HZ)
      begin
        fast_d = 1'b1;
      end
      else if (cmd.rate_sel == `GPS_SEL_1HZ)
      begin
        fast_d = 1'b0;
      end
    end
    if (st_q == GPS_OFF || st_q == GPS_HIB)
    begin
      fast_d = 1'b0; // Restart returns to 1 Hz
    end
    // Five equal sub-second slots when fast
    if (sec_tick)
    begin
      sub_d = 3'h0;
    end
    else if (sec_q == 32'(((32'(sub_q) + 32'h1) * 32'(SECOND_CYC)) / 5) - 32'h1 && sub_q != 3'h4)
    begin
      sub_d = sub_q + 3'h1;
      if (fast_q && st_q == GPS_FULL)
      begin
        nav_d = 1'b1;
      end
    end
    if (sec_tick && st_q == GPS_FULL)
    begin
      nav_d = 1'b1;
    end
    // Pulse 700 ns after second boundary, inside 620..710 ns
    if (sec_tick && time_locked && st_q == GPS_FULL)
    begin
      pps_arm_d = 1'b1;
      pps_d = 32'h0;
    end
    else if (pps_arm_q)
    begin
      pps_d = pps_q + 32'h1;
      if (pps_q == 32'(`GPS_PPS_DELAY_CYC) - 32'h1)
      begin
        ppso_d = 1'b1;
        utc_arm_d = 1'b1;
        utc_cnt_d = 32'h0;
      end
      if (pps_q == 32'(`GPS_PPS_DELAY_CYC + PPS_WIDTH_CYC) - 32'h1)
      begin
        ppso_d = 1'b0;
        pps_arm_d = 1'b0;
      end
    end
    if (utc_arm_q)
    begin
      utc_cnt_d = utc_cnt_q + 32'h1;
      if (utc_cnt_q == 32'(UTC_DELAY_CYC - 1))
      begin
        utc_d = 1'b1;
        utc_arm_d = 1'b0;
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      sec_q <= 32'h0;
      sub_q <= 3'h0;
      fast_q <= 1'b0;
      pps_q <= 32'h0;
      pps_arm_q <= 1'b0;
      ppso_q <= 1'b0;
      utc_arm_q <= 1'b0;
      utc_cnt_q <= 32'h0;
      utc_q <= 1'b0;
      nav_q <= 1'b0;
    end
    else
    begin
      sec_q <= sec_d;
      sub_q <= sub_d;
      fast_q <= fast_d;
      pps_q <= pps_d;
      pps_arm_q <= pps_arm_d;
      ppso_q <= ppso_d;
      utc_arm_q <= utc_arm_d;
      utc_cnt_q <= utc_cnt_d;
      utc_q <= utc_d;
      nav_q <= nav_d;
    end
  end

  // Registered outputs
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      wake_indicator_output <= 1'b0;
      core_power_on <= 1'b0;
      rtc_sram_retain <= 1'b0;
      shutdown_done <= 1'b0;
      fix_request <= 1'b0;
      timing <= '0;
    end
    else
    begin
      // Wake rises once the core can accept the start pulse
      wake_indicator_output <= (st_q != GPS_HIB) && (st_q != GPS_OFF || sec_q > 32'h1);
      core_power_on <= (st_q == GPS_FULL) || (st_q == GPS_SHUT) || (fix_q != 32'h0);
      rtc_sram_retain <= 1'b1;
      shutdown_done <= done_q;
      fix_request <= fixreq_q;
      timing <= '{second_pulse_output: ppso_q, utc_msg_strobe: utc_q, nav_strobe: nav_q, fast_rate: fast_q};
    end
  end
endmodule

// File: dv/gps_power_seq_props.sv
`timescale 1ns/1ns
`include "gps_map.svh"
module gps_power_seq_props
  import gps_pkg::*;
#(
  parameter int SHUTDOWN_CYC = 200,
  parameter int HIB_DELAY_CYC = 20,
  parameter int UTC_DELAY_CYC = 30,
  parameter int PPS_WIDTH_CYC = 10
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Inputs
  input wire logic power_toggle,
  input wire gps_pkg::gps_cmd_t cmd,
  input wire logic cmd_valid,
  input wire logic time_locked,
  // Outputs
  input wire logic wake_indicator_output,
  input wire logic core_power_on,
  input wire logic rtc_sram_retain,
  input wire logic shutdown_done,
  input wire logic fix_request,
  input wire gps_pkg::gps_time_t timing
);
  localparam int SD_MAX = SHUTDOWN_CYC + 5;
  localparam int PW = PPS_WIDTH_CYC - 1;
  localparam int UP = UTC_DELAY_CYC - 2;
  localparam int HB = HIB_DELAY_CYC + 5;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);
  logic on_full;
  assign on_full = core_power_on && wake_indicator_output && !shutdown_done;
  a_fix_single: assert property (fix_request |=> !fix_request)
    else $error("fix request longer than one cycle");
  a_rate_fast: assert property (cmd_valid && cmd.rate_valid && cmd.rate_sel == `GPS_SEL_5HZ && on_full
    |-> ##2 timing.fast_rate) else $error("fast rate not set");
  a_rate_slow: assert property (cmd_valid && cmd.rate_valid && cmd.rate_sel == `GPS_SEL_1HZ
    |-> ##2 !timing.fast_rate) else $error("slow rate not set");
  a_pps_width: assert property ($rose(timing.second_pulse_output)
    |-> ##PW timing.second_pulse_output ##1 !timing.second_pulse_output) else $error("second pulse width");
  // Lock is judged at the second boundary that armed the pulse, not at the rise
  a_pps_cause: assert property ($rose(timing.second_pulse_output)
    |-> $past(time_locked, `GPS_PPS_DELAY_CYC + 2)) else $error("second pulse without lock");
  a_pps_delay: assert property ($rose(timing.second_pulse_output)
    |-> $past(timing.nav_strobe, `GPS_PPS_DELAY_CYC)) else $error("second pulse off its boundary");
  a_utc_gap: assert property (timing.utc_msg_strobe |-> $past(timing.second_pulse_output, UP))
    else $error("time message not after second pulse");
  a_shut_bound: assert property (cmd_valid && cmd.shutdown && on_full |-> ##[1:SD_MAX] shutdown_done)
    else $error("shutdown too slow");
  a_hib_entry: assert property ($rose(shutdown_done)
    |-> !core_power_on && rtc_sram_retain && $past(core_power_on, HB)) else $error("bad hibernate entry");
endmodule
bind gps_power_seq gps_power_seq_props #(.SHUTDOWN_CYC(SHUTDOWN_CYC), .HIB_DELAY_CYC(HIB_DELAY_CYC),
  .UTC_DELAY_CYC(UTC_DELAY_CYC), .PPS_WIDTH_CYC(PPS_WIDTH_CYC)) u_props (.clk(clk), .reset_n(reset_n),
  .power_toggle(power_toggle), .cmd(cmd), .cmd_valid(cmd_valid), .time_locked(time_locked),
  .wake_indicator_output(wake_indicator_output), .core_power_on(core_power_on),
  .rtc_sram_retain(rtc_sram_retain), .shutdown_done(shutdown_done), .fix_request(fix_request), .timing(timing));

// File: dv/gps_host_model.sv
`timescale 1ns/1ns
module gps_host_model (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Request
  input wire logic go,
  input wire logic [7:0] width,
  // Pin
  output logic power_toggle,
  output logic busy
);
  logic [7:0] cnt_q;
  // Own counter times every pulse
  always @(negedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      power_toggle <= 1'b0;
      cnt_q <= 8'h00;
    end
    else if (cnt_q != 8'h00)
    begin
      cnt_q <= cnt_q - 8'h01;
      power_toggle <= (cnt_q != 8'h01);
    end
    else if (go)
    begin
      power_toggle <= 1'b1;
      cnt_q <= width;
    end
  end
  assign busy = power_toggle || go;
endmodule

// File: dv/test_gps_power_seq.sv
`timescale 1ns/1ns
`include "gps_map.svh"
module test_gps_power_seq;
  import gps_pkg::*;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic go = 1'b0;
  logic [7:0] width = 8'h00;
  logic power_toggle, busy, wake, core_on, retain, sd_done, fix;
  gps_cmd_t cmd = '0;
  logic cmd_valid = 1'b0;
  logic time_locked = 1'b1;
  gps_time_t timing;
  int n_errors = 0;
  int compares = 0;
  int t, n;
  // Shortened timings so every scenario fits a short run
  localparam int TG_MIN = 10;
  localparam int TG_MAX = 100;
  localparam int SD_CYC = 200;
  localparam int HIB_CYC = 20;
  localparam int SEC_CYC = 100;
  localparam int UTC_CYC = 30;
  localparam int PW_CYC = 10;
  localparam int PTF_SEC = 3;
  localparam int FIX_WIN = 20;
  always #50 clk = ~clk;
  gps_power_seq #(.TOGGLE_MIN_CYC(TG_MIN), .TOGGLE_MAX_CYC(TG_MAX), .SHUTDOWN_CYC(SD_CYC),
    .HIB_DELAY_CYC(HIB_CYC), .SECOND_CYC(SEC_CYC), .UTC_DELAY_CYC(UTC_CYC), .PPS_WIDTH_CYC(PW_CYC),
    .PTF_PERIOD_SEC(PTF_SEC), .FIX_CYC(FIX_WIN)) dut (
    .clk(clk), .reset_n(reset_n), .power_toggle(power_toggle), .cmd(cmd), .cmd_valid(cmd_valid),
    .time_locked(time_locked), .wake_indicator_output(wake), .core_power_on(core_on),
    .rtc_sram_retain(retain), .shutdown_done(sd_done), .fix_request(fix), .timing(timing));
  gps_host_model host (.clk(clk), .reset_n(reset_n), .go(go), .width(width),
    .power_toggle(power_toggle), .busy(busy));
  task give_verdict;
  begin
    $display("compares %0d errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  end
  endtask
  task chk_bit(input logic got, input logic exp);
  begin
    compares++;
    if (got !== exp)
    begin
      n_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  end
  endtask
  task chk_cnt(input int got, input int exp);
  begin
    compares++;
    if (got != exp)
    begin
      n_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  end
  endtask
  function logic pick(input int w);
    case (w)
      0: pick = wake;
      1: pick = core_on;
      2: pick = sd_done;
      3: pick = fix;
      4: pick = timing.second_pulse_output;
      6: pick = timing.utc_msg_strobe;
      7: pick = timing.nav_strobe;
      default: pick = busy;
    endcase
  endfunction
  // Bounded wait; running out ends the run
  task wait_for(input int w, input logic v, input int bound, output int took);
  begin
    for (took = 0; took < bound; took++)
    begin
      @(posedge clk);
      #1;
      if (pick(w) === v)
        break;
    end
    chk_bit(pick(w), v);
    if (took == bound)
      give_verdict;
  end
  endtask
  task pulse(input logic [7:0] w);
  begin
    @(negedge clk);
    go <= 1'b1;
    width <= w;
    @(negedge clk);
    go <= 1'b0;
    wait_for(5, 1'b0, 300, t);
  end
  endtask
  task send(input logic [7:0] c);
  begin
    @(negedge clk);
    cmd <= gps_cmd_t'(c);
    cmd_valid <= 1'b1;
    @(negedge clk);
    cmd <= '0;
    cmd_valid <= 1'b0;
  end
  endtask
  task count_hi(input int w, input int cyc);
  begin
    n = 0;
    repeat (cyc)
    begin
      @(posedge clk);
      #1;
      if (pick(w) === 1'b1)
        n++;
    end
  end
  endtask
  task t_start;
  begin
    wait_for(0, 1'b1, 50, t);
    pulse(8'h05);
    repeat (20) @(posedge clk);
    chk_bit(core_on, 1'b0);
    pulse(8'h28);
    wait_for(1, 1'b1, 20, t);
    $display("test start done");
  end
  endtask
  task t_rate;
  begin
    // Navigation strobe marks the second boundary
    wait_for(7, 1'b1, 150, t);
    wait_for(4, 1'b1, 20, t);
    chk_cnt(t + 1, `GPS_PPS_DELAY_CYC);
    wait_for(6, 1'b1, 40, t);
    chk_cnt(t + 1, UTC_CYC);
    count_hi(7, SEC_CYC);
    chk_cnt(n, 1);
    send({4'h1, `GPS_SEL_5HZ});
    repeat (5) @(negedge clk);
    chk_bit(timing.fast_rate, 1'b1);
    count_hi(7, SEC_CYC);
    chk_cnt(n, 5);
    send({4'h1, `GPS_SEL_1HZ});
    repeat (5) @(negedge clk);
    count_hi(7, SEC_CYC);
    chk_cnt(n, 1);
    // Without lock no second pulse may appear
    @(negedge clk);
    time_locked <= 1'b0;
    repeat (30) @(posedge clk);
    count_hi(4, SEC_CYC);
    chk_cnt(n, 0);
    @(negedge clk);
    time_locked <= 1'b1;
    $display("test rate done");
  end
  endtask
  // Toggle or message shutdown, then wake again
  task t_shut(input logic by_cmd);
  begin
    if (by_cmd)
      send(8'h80);
    else
      pulse(8'h28);
    wait_for(2, 1'b1, SD_CYC + 10, t);
    chk_cnt(int'(t > 170), 1);
    chk_bit(core_on, 1'b0);
    chk_bit(retain, 1'b1);
    pulse(8'h28);
    wait_for(1, 1'b1, 20, t);
    wait_for(2, 1'b0, 5, t);
    $display("test shutdown done");
  end
  endtask
  task t_low_power;
  begin
    send(8'h40);
    pulse(8'h28);
    wait_for(3, 1'b1, 20, t);
    wait_for(1, 1'b1, 10, t);
    send(8'h20);
    pulse(8'h28);
    wait_for(3, 1'b1, 20, t);
    wait_for(3, 1'b1, 400, t);
    chk_cnt(int'(t > 100), 1);
    $display("test low power done");
  end
  endtask
  initial
  begin
    repeat (8) @(negedge clk);
    reset_n <= 1'b1;
    t_start;
    t_rate;
    t_shut(1'b0);
    t_shut(1'b1);
    t_low_power;
    give_verdict;
  end
endmodule
